// [hdl/pbm_port_b_mux.sv]
/*
 * port b pins 7..1 alternate-function override mux.
 * assumes port register bits and peripheral controls are synchronous
 * to mclk; pad input is already synchronised upstream.
 */
//
// Overview of operation
// (R1) clock use of bit 7 reads zero
// (R2) clock use of bit 6 reads zero
// (R3) bit 7 is crystal pin two
// (R4) bit 6 is clock input unless rc
// (R5) timer oscillator only with rc and async
// (R6) async and no ext clock frees bit 7
// (R7) async frees bit 6 as amplifier input
// (R8) spi slave forces bit 5 input
// (R9) forced inputs keep pull-up from out bit
// (R10) usart0 clock direction from dir bit 5
// (R11) usart0 ext clock only in sync mode
// (R12) spi master forces bit 4 input
// (R13) usart1 receiver forces bit 4 input
// (R14) spi slave forces bit 3 input
// (R15) usart1 transmitter forces bit 3 output
// (R16) software sets dir 3 for timer2 a
// (R17) spi slave forces bit 2 input
// (R18) spi slave active while select low
// (R19) software sets dir 2 for timer1 b
// (R20) software sets dir 1 for timer1 a
// (R21) bits 1..7 feed pin change inputs
// (R22) pull-up per 010 rule or override
// (R23) direction override beats dir bit
// (R24) overrides never change stored bits
`timescale 1ns/1ps
module pbm_port_b_mux (
   input  wire logic                 mclk,
   input  wire logic                 rstn,
   // stored port register bits and pad inputs
   input  wire logic [7:0]           dirBits,
   input  wire logic [7:0]           outBits,
   input  wire logic [7:0]           padIn,
   input  wire logic                 globalPullupDisable,
   // clock configuration
   input  wire pbm_pkg::pbm_clksrc_t chipClockSource,
   input  wire logic                 asyncTimer2Select,
   input  wire logic                 externalClockSelect,
   // peripheral controls
   input  wire logic                 spi0Enable,
   input  wire logic                 spi0Master,
   input  wire logic                 spi0ClockOut,
   input  wire logic                 spi0SlaveOut,
   input  wire logic                 spi0MasterOut,
   input  wire logic                 usart0SyncMode,
   input  wire logic                 usart0ClockOut,
   input  wire logic                 usart1RxEnable,
   input  wire logic                 usart1TxEnable,
   input  wire logic                 usart1TxData,
   input  wire logic                 timer2CmpAEnable,
   input  wire logic                 timer2CmpA,
   input  wire logic                 timer1CmpBEnable,
   input  wire logic                 timer1CmpB,
   input  wire logic                 timer1CmpAEnable,
   input  wire logic                 timer1CmpA,
   // pad side
   output logic [7:1]                padOut,
   output logic [7:1]                padOe,
   output logic [7:1]                padPullup,
   output logic                      crystalPinMode7,
   output logic                      crystalPinMode6,
   // read-back and peripheral side
   output logic [7:0]                dirReadback,
   output logic [7:0]                outReadback,
   output logic [7:0]                inReadback,
   output logic [7:1]                pinChangeSrc,
   output logic                      spi0ClockIn,
   output logic                      spi0MasterIn,
   output logic                      spi0SlaveIn,
   output logic                      spi0SlaveActive,
   output logic                      usart0ClockIn,
   output logic                      usart0ClockIsOutput,
   output logic                      usart1RxData
);
   import pbm_pkg::*;

   logic rstnSync;
   pbm_reset_sync u_rst (
      .mclk     (mclk),
      .rstn     (rstn),
      .rstnSync (rstnSync)
   );

   // ***************************************************
   // clock pin ownership
   // ***************************************************
   logic rcClock;
   logic clockUse7;
   logic clockUse6;
   logic tosc7;
   logic tosc6;

   always_comb begin
      rcClock   = (chipClockSource == PBM_CLK_RC);
      // timer oscillator use needs the rc clock
      tosc6     = rcClock && asyncTimer2Select;                          // [R5] [R7]
      tosc7     = rcClock && asyncTimer2Select && !externalClockSelect;  // [R5] [R6]
      clockUse7 = (chipClockSource == PBM_CLK_XTAL) || tosc7;            // [R3]
      clockUse6 = !rcClock || tosc6;                                     // [R4]
   end

   // ***************************************************
   // per-pin override terms
   // ***************************************************
   logic [7:1] puEn;
   logic [7:1] puVal;
   logic [7:1] ddEn;
   logic [7:1] ddVal;
   logic [7:1] pvEn;
   logic [7:1] pvVal;
   logic       spiSlave;
   logic       spiMstr;
   logic       xckOut;

   always_comb begin
      spiSlave = spi0Enable && !spi0Master;
      spiMstr  = spi0Enable && spi0Master;
      xckOut   = usart0SyncMode && dirBits[BIT_SCK];                     // [R10] [R11]
      puEn  = '0;
      puVal = '0;
      ddEn  = '0;
      ddVal = '0;
      pvEn  = '0;
      pvVal = '0;
      // clock pins: driver and pull-up off, stored bits untouched
      puEn[BIT_OSC_OUT] = clockUse7;                                     // [R3] [R6]
      ddEn[BIT_OSC_OUT] = clockUse7;
      puEn[BIT_OSC_IN]  = clockUse6;                                     // [R4] [R7]
      ddEn[BIT_OSC_IN]  = clockUse6;
      // sck: slave forces input, pull-up still from out bit
      puEn[BIT_SCK]  = spiSlave;                                         // [R8] [R9]
      puVal[BIT_SCK] = outBits[BIT_SCK] && !globalPullupDisable;
      ddEn[BIT_SCK]  = spiSlave;
      pvEn[BIT_SCK]  = spiMstr || xckOut;
      pvVal[BIT_SCK] = spiMstr ? spi0ClockOut : usart0ClockOut;
      // miso: master or usart1 receiver forces input
      puEn[BIT_MISO]  = spiMstr || usart1RxEnable;                       // [R12] [R13] [R9]
      puVal[BIT_MISO] = outBits[BIT_MISO] && !globalPullupDisable;
      ddEn[BIT_MISO]  = spiMstr || usart1RxEnable;
      pvEn[BIT_MISO]  = spiSlave;
      pvVal[BIT_MISO] = spi0SlaveOut;
      // mosi: slave forces input, transmitter forces output
      if (usart1TxEnable) begin
         ddEn[BIT_MOSI]  = 1'h1;                                         // [R15]
         ddVal[BIT_MOSI] = 1'h1;
      end else begin
         puEn[BIT_MOSI]  = spiSlave;                                     // [R14] [R9]
         puVal[BIT_MOSI] = outBits[BIT_MOSI] && !globalPullupDisable;
         ddEn[BIT_MOSI]  = spiSlave;
      end
      pvEn[BIT_MOSI]  = spiMstr || timer2CmpAEnable || usart1TxEnable;   // [R16]
      pvVal[BIT_MOSI] = usart1TxEnable ? usart1TxData
                      : (spiMstr ? spi0MasterOut : timer2CmpA);
      // ss: slave forces input
      puEn[BIT_SS]  = spiSlave;                                          // [R17] [R9]
      puVal[BIT_SS] = outBits[BIT_SS] && !globalPullupDisable;
      ddEn[BIT_SS]  = spiSlave;
      pvEn[BIT_SS]  = timer1CmpBEnable;                                  // [R19]
      pvVal[BIT_SS] = timer1CmpB;
      // timer1 compare a
      pvEn[BIT_T1A]  = timer1CmpAEnable;                                 // [R20]
      pvVal[BIT_T1A] = timer1CmpA;
   end

   // ***************************************************
   // pin cells
   // ***************************************************
   logic [7:1] pullD;
   logic [7:1] oeD;
   logic [7:1] valD;

   for (genvar i = PIN_LO; i <= PIN_HI; i++) begin : g_pin
      pbm_pin_cell u_cell (
         .dirBit               (dirBits[i]),                             // [R24]
         .outBit               (outBits[i]),
         .globalPullupDisable  (globalPullupDisable),
         .pullupOverrideEnable (puEn[i]),
         .pullupOverrideValue  (puVal[i]),
         .dirOverrideEnable    (ddEn[i]),
         .dirOverrideValue     (ddVal[i]),
         .valueOverrideEnable  (pvEn[i]),
         .valueOverrideValue   (pvVal[i]),
         .pullupOn             (pullD[i]),
         .driveOn              (oeD[i]),
         .driveVal             (valD[i])
      );
   end

   // ***************************************************
   // read-back and peripheral inputs
   // ***************************************************
   logic [7:0] dirRbD;
   logic [7:0] outRbD;
   logic [7:0] inRbD;
   logic [7:1] pcD;

   always_comb begin
      dirRbD = dirBits;
      outRbD = outBits;
      inRbD  = padIn;
      // zeroed read-back hides pins owned by a clock
      if (clockUse7) begin
         dirRbD[BIT_OSC_OUT] = 1'h0;                                     // [R1]
         outRbD[BIT_OSC_OUT] = 1'h0;
         inRbD[BIT_OSC_OUT]  = 1'h0;
      end
      if (clockUse6) begin
         dirRbD[BIT_OSC_IN] = 1'h0;                                      // [R2]
         outRbD[BIT_OSC_IN] = 1'h0;
         inRbD[BIT_OSC_IN]  = 1'h0;
      end
      pcD = padIn[7:1];                                                  // [R21]
   end

   // ***************************************************
   // output next values
   // ***************************************************
   logic [7:1] padOut_d;
   logic [7:1] padOe_d;
   logic [7:1] padPullup_d;
   logic       crystalPinMode7_d;
   logic       crystalPinMode6_d;
   logic [7:0] dirReadback_d;
   logic [7:0] outReadback_d;
   logic [7:0] inReadback_d;
   logic [7:1] pinChangeSrc_d;
   logic       spi0ClockIn_d;
   logic       spi0MasterIn_d;
   logic       spi0SlaveIn_d;
   logic       spi0SlaveActive_d;
   logic       usart0ClockIn_d;
   logic       usart0ClockIsOutput_d;
   logic       usart1RxData_d;

   always_comb begin
      padOut_d              = valD;
      padOe_d               = oeD;
      padPullup_d           = pullD;
      crystalPinMode7_d     = clockUse7;
      crystalPinMode6_d     = clockUse6;
      dirReadback_d         = dirRbD;
      outReadback_d         = outRbD;
      inReadback_d          = inRbD;
      pinChangeSrc_d        = pcD;
      spi0ClockIn_d         = padIn[BIT_SCK];
      spi0MasterIn_d        = padIn[BIT_MISO];
      spi0SlaveIn_d         = padIn[BIT_MOSI];
      // slave select comes from the pad, never from the dir bit
      spi0SlaveActive_d     = spiSlave && !padIn[BIT_SS];                // [R18]
      usart0ClockIn_d       = usart0SyncMode && padIn[BIT_SCK];          // [R11]
      usart0ClockIsOutput_d = xckOut;                                    // [R10]
      usart1RxData_d        = padIn[BIT_MISO];
   end

   // ***************************************************
   // output registers
   // ***************************************************
   // one edge of latency on every pad and read-back path
   always_ff @(posedge mclk or negedge rstnSync) begin
      if (!rstnSync) begin
         padOut              <= '0;
         padOe               <= '0;
         padPullup           <= '0;
         crystalPinMode7     <= RST_BIT;
         crystalPinMode6     <= RST_BIT;
         dirReadback         <= RST_BYTE;
         outReadback         <= RST_BYTE;
         inReadback          <= RST_BYTE;
         pinChangeSrc        <= '0;
         spi0ClockIn         <= RST_BIT;
         spi0MasterIn        <= RST_BIT;
         spi0SlaveIn         <= RST_BIT;
         spi0SlaveActive     <= RST_BIT;
         usart0ClockIn       <= RST_BIT;
         usart0ClockIsOutput <= RST_BIT;
         usart1RxData        <= RST_BIT;
      end else begin
         padOut              <= padOut_d;
         padOe               <= padOe_d;
         padPullup           <= padPullup_d;
         crystalPinMode7     <= crystalPinMode7_d;
         crystalPinMode6     <= crystalPinMode6_d;
         dirReadback         <= dirReadback_d;
         outReadback         <= outReadback_d;
         inReadback          <= inReadback_d;
         pinChangeSrc        <= pinChangeSrc_d;
         spi0ClockIn         <= spi0ClockIn_d;
         spi0MasterIn        <= spi0MasterIn_d;
         spi0SlaveIn         <= spi0SlaveIn_d;
         spi0SlaveActive     <= spi0SlaveActive_d;
         usart0ClockIn       <= usart0ClockIn_d;
         usart0ClockIsOutput <= usart0ClockIsOutput_d;
         usart1RxData        <= usart1RxData_d;
      end
   end
endmodule

// [hdl/pbm_pkg.sv]
/*
 * shared constants for the port b alternate-function override block.
 * assumes pins 1 to 7 only; pin 0 lives elsewhere.
 */
package pbm_pkg;
   localparam int unsigned PIN_LO    = 1;
   localparam int unsigned PIN_HI    = 7;
   localparam int unsigned NPIN      = 8;
   localparam int unsigned BIT_OSC_OUT = 7;
   localparam int unsigned BIT_OSC_IN  = 6;
   localparam int unsigned BIT_SCK     = 5;
   localparam int unsigned BIT_MISO    = 4;
   localparam int unsigned BIT_MOSI    = 3;
   localparam int unsigned BIT_SS      = 2;
   localparam int unsigned BIT_T1A     = 1;
   localparam logic [7:0]  RST_BYTE  = 8'h00;
   localparam logic        RST_BIT   = 1'h0;
   localparam logic [1:0]  RST_SYNC  = 2'h0;

   typedef enum logic [1:0] {
      PBM_CLK_RC   = 2'b00,
      PBM_CLK_XTAL = 2'b01,
      PBM_CLK_EXT  = 2'b10
   } pbm_clksrc_t;
endpackage

// [hdl/pbm_reset_sync.sv]
/*
 * two-stage reset release synchroniser.
 * assumes rstn may drop at any time; release is aligned to mclk.
 */
`timescale 1ns/1ps
module pbm_reset_sync (
   input  wire logic mclk,
   input  wire logic rstn,
   output logic      rstnSync
);
   import pbm_pkg::*;
   logic [1:0] sync_q;
   logic [1:0] sync_d;

   always_comb begin
      sync_d = {sync_q[0], 1'b1};
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         sync_q <= RST_SYNC;
      end else begin
         sync_q <= sync_d;
      end
   end

   assign rstnSync = sync_q[1];
endmodule

// [hdl/pbm_pin_cell.sv]
/*
 * one generic pin override cell: pull-up, driver enable, output value.
 * assumes override inputs already computed by the owning peripherals.
 */
`timescale 1ns/1ps
module pbm_pin_cell (
   input  wire logic dirBit,
   input  wire logic outBit,
   input  wire logic globalPullupDisable,
   input  wire logic pullupOverrideEnable,
   input  wire logic pullupOverrideValue,
   input  wire logic dirOverrideEnable,
   input  wire logic dirOverrideValue,
   input  wire logic valueOverrideEnable,
   input  wire logic valueOverrideValue,
   output logic      pullupOn,
   output logic      driveOn,
   output logic      driveVal
);
   always_comb begin
      pullupOn = pullupOverrideEnable ? pullupOverrideValue
               : (!dirBit && outBit && !globalPullupDisable);           // [R22]
      driveOn  = dirOverrideEnable ? dirOverrideValue : dirBit;         // [R23]
      driveVal = valueOverrideEnable ? valueOverrideValue : outBit;
   end
endmodule

// [verif/pbm_port_b_mux_properties.sv]
/* port b override checker: drive, pull-up and read-back relations.
   assumes outputs lag inputs by one mclk and reset release takes two edges. */
`timescale 1ns/1ps
module pbm_port_b_mux_checker
   import pbm_pkg::*;
(
   input wire logic                 mclk,
   input wire logic                 rstn,
   input wire logic [7:0]           dirBits,
   input wire logic [7:0]           outBits,
   input wire logic [7:0]           padIn,
   input wire logic                 globalPullupDisable,
   input wire pbm_pkg::pbm_clksrc_t chipClockSource,
   input wire logic                 asyncTimer2Select,
   input wire logic                 spi0Enable,
   input wire logic                 spi0Master,
   input wire logic                 usart1RxEnable,
   input wire logic                 usart1TxEnable,
   input wire logic                 usart1TxData,
   input wire logic [7:1]           padOut,
   input wire logic [7:1]           padOe,
   input wire logic [7:1]           padPullup,
   input wire logic                 crystalPinMode7,
   input wire logic                 crystalPinMode6,
   input wire logic [7:0]           dirReadback,
   input wire logic [7:0]           outReadback,
   input wire logic [7:0]           inReadback,
   input wire logic [7:1]           pinChangeSrc,
   input wire logic                 spi0SlaveActive
);
   logic [1:0] upCnt_q;
   logic [1:0] upCnt_d;
   logic       live;
   assign live = (upCnt_q == 2'h3);
   always_comb begin
      upCnt_d = live ? upCnt_q : upCnt_q + 2'h1;
   end
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) upCnt_q <= 2'h0;
      else upCnt_q <= upCnt_d;
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (!rstn);
   a_clk7_reads_zero: assert property (crystalPinMode7 |->
      {dirReadback[7], outReadback[7], inReadback[7]} == 3'h0) else $error("bit7 reads");
   a_clk6_reads_zero: assert property (crystalPinMode6 |->
      {dirReadback[6], outReadback[6], inReadback[6]} == 3'h0) else $error("bit6 reads");
   a_xtal_takes_7: assert property (live && chipClockSource == PBM_CLK_XTAL
      |=> crystalPinMode7 && !padOe[7]) else $error("bit7 not freed");
   a_async_takes_6: assert property (live && asyncTimer2Select
      |=> crystalPinMode6 && !padOe[6] && !padPullup[6]) else $error("bit6 not freed");
   a_slave_in5: assert property (live && spi0Enable && !spi0Master |=> !padOe[5])
      else $error("bit5 driven");
   a_master_in4: assert property (live && spi0Enable && spi0Master |=> !padOe[4])
      else $error("bit4 driven");
   a_rx_pullup4: assert property (live && usart1RxEnable |=> !padOe[4] &&
      padPullup[4] == $past(outBits[4] & !globalPullupDisable)) else $error("bit4 rx");
   a_tx_out3: assert property (live && usart1TxEnable |=> padOe[3] &&
      padOut[3] == $past(usart1TxData)) else $error("bit3 tx");
   a_select_low: assert property (live && spi0Enable && !spi0Master && !padIn[2]
      |=> spi0SlaveActive) else $error("slave idle");
   a_pin_change: assert property (live |=> pinChangeSrc == $past(padIn[7:1]))
      else $error("pin change");
   a_plain_pullup1: assert property (live |=> padPullup[1] ==
      $past(!dirBits[1] & outBits[1] & !globalPullupDisable)) else $error("bit1 pull-up");
   c_slave: cover property (live && spi0Enable && !spi0Master && !padIn[2]);
   c_tx: cover property (live && usart1TxEnable);
   c_xtal: cover property (crystalPinMode7 && crystalPinMode6);
endmodule
bind pbm_port_b_mux pbm_port_b_mux_checker u_chk (.mclk, .rstn, .dirBits, .outBits, .padIn,
   .globalPullupDisable, .chipClockSource, .asyncTimer2Select, .spi0Enable, .spi0Master,
   .usart1RxEnable, .usart1TxEnable, .usart1TxData, .padOut, .padOe, .padPullup,
   .crystalPinMode7, .crystalPinMode6, .dirReadback, .outReadback, .inReadback,
   .pinChangeSrc, .spi0SlaveActive);

// [verif/pbm_pad_model.sv]
/* pad and far-side model: resolves pins 7..1 from driver, outside and pull-up; pin 0 from outside only.
   the bench drives random outside levels on any pin; an enabled driver wins over them. */
`timescale 1ns/1ps
module pbm_pad_model (
   input  wire logic       mclk,
   input  wire logic [7:1] padOut,
   input  wire logic [7:1] padOe,
   input  wire logic [7:1] padPullup,
   input  wire logic [7:0] extLevel,
   input  wire logic [7:0] extDrive,
   output logic [7:0]      padIn
);
   logic wiggle = 1'b0;
   always @(posedge mclk) wiggle <= !wiggle;
   always_comb begin
      padIn[0] = extLevel[0];
      for (int i = 1; i < 8; i++) begin
         if (padOe[i]) padIn[i] = padOut[i];
         else if (extDrive[i]) padIn[i] = extLevel[i];
         else if (padPullup[i]) padIn[i] = 1'b1;
         else padIn[i] = wiggle ^ i[0];
      end
   end
endmodule

// [verif/pbm_port_b_mux_tb.sv]
/* self-checking bench for the port b override mux.
   assumes a one-cycle registered answer; expectation lags a cycle. */
`timescale 1ns/1ps
module pbm_port_b_mux_tb;
   import pbm_pkg::*;
   typedef struct packed {
      logic [7:1] oe, pu, po, pm, pc;
      logic [5:0] rb;
      logic [4:0] misc;
      logic [17:0] rbLo;
      logic [3:0] pin;
   } pbm_exp_t;
   logic mclk = 1'b0, rstn, armed, chkOn;
   logic [7:0] dirBits, outBits, padIn, extLevel, extDrive;
   logic globalPullupDisable, asyncTimer2Select, externalClockSelect, spi0Enable, spi0Master;
   logic spi0ClockOut, spi0SlaveOut, spi0MasterOut, usart0SyncMode, usart0ClockOut;
   logic usart1RxEnable, usart1TxEnable, usart1TxData, timer2CmpAEnable, timer2CmpA;
   logic timer1CmpBEnable, timer1CmpB, timer1CmpAEnable, timer1CmpA;
   logic crystalPinMode7, crystalPinMode6, spi0ClockIn, spi0MasterIn, spi0SlaveIn;
   logic spi0SlaveActive, usart0ClockIn, usart0ClockIsOutput, usart1RxData;
   logic [7:1] padOut, padOe, padPullup, pinChangeSrc;
   logic [7:0] dirReadback, outReadback, inReadback;
   pbm_clksrc_t chipClockSource;
   pbm_exp_t eq;
   int n_fail = 0, n_checks = 0, cycles = 0;
   always #25 mclk = !mclk;
   pbm_port_b_mux u_dut (.mclk, .rstn, .dirBits, .outBits, .padIn, .globalPullupDisable,
      .chipClockSource, .asyncTimer2Select, .externalClockSelect, .spi0Enable, .spi0Master,
      .spi0ClockOut, .spi0SlaveOut, .spi0MasterOut, .usart0SyncMode, .usart0ClockOut,
      .usart1RxEnable, .usart1TxEnable, .usart1TxData, .timer2CmpAEnable, .timer2CmpA,
      .timer1CmpBEnable, .timer1CmpB, .timer1CmpAEnable, .timer1CmpA, .padOut, .padOe,
      .padPullup, .crystalPinMode7, .crystalPinMode6, .dirReadback, .outReadback,
      .inReadback, .pinChangeSrc, .spi0ClockIn, .spi0MasterIn, .spi0SlaveIn,
      .spi0SlaveActive, .usart0ClockIn, .usart0ClockIsOutput, .usart1RxData);
   pbm_pad_model u_pad (.mclk, .padOut, .padOe, .padPullup, .extLevel, .extDrive, .padIn);
   function automatic pbm_exp_t calc();
      pbm_exp_t e;
      logic rc, sS, sM, c7, c6;
      logic [7:1] fin, cu;
      rc = (chipClockSource == PBM_CLK_RC);
      sS = spi0Enable & !spi0Master;
      sM = spi0Enable & spi0Master;
      c7 = (chipClockSource == PBM_CLK_XTAL) | (rc & asyncTimer2Select & !externalClockSelect);
      c6 = !rc | asyncTimer2Select;
      cu = {c7, c6, 5'h00};
      fin = {2'b00, sS, sM | usart1RxEnable, sS & !usart1TxEnable, sS, 1'b0};
      e.oe = dirBits[7:1] & ~fin & ~cu;
      e.oe[3] = usart1TxEnable | e.oe[3];
      e.pu = (fin | ~dirBits[7:1]) & outBits[7:1] & {7{!globalPullupDisable}} & ~cu;
      e.pm = 7'h7f;
      e.po = outBits[7:1];
      e.po[5] = sM ? spi0ClockOut : (usart0SyncMode & dirBits[5]) ? usart0ClockOut : outBits[5];
      e.po[4] = sS ? spi0SlaveOut : outBits[4];
      e.po[3] = usart1TxEnable ? usart1TxData : sM ? spi0MasterOut
              : timer2CmpAEnable ? timer2CmpA : outBits[3];
      e.po[2] = timer1CmpBEnable ? timer1CmpB : outBits[2];
      e.po[1] = timer1CmpAEnable ? timer1CmpA : outBits[1];
      e.pc = padIn[7:1];
      e.rb = {dirBits[7:6], outBits[7:6], padIn[7:6]} & ~{3{c7, c6}};
      e.misc = {c7, c6, sS & !padIn[2], usart0SyncMode & dirBits[5], padIn[4]};
      e.rbLo = {dirBits[5:0], outBits[5:0], padIn[5:0]};
      e.pin = {padIn[5], padIn[4], padIn[3], usart0SyncMode & padIn[5]};
      return e;
   endfunction
   task automatic check(input logic ok, input string msg);
      n_checks++;
      if (ok !== 1'b1) begin
         n_fail++;
         $display("unexpected at %0t: %s", $time, msg);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   always @(posedge mclk) begin
      if (chkOn) begin
         check(padOe === eq.oe, "drive enable");
         check((padPullup & eq.pm) === (eq.pu & eq.pm), "pull-up");
         check((padOut & eq.oe) === (eq.po & eq.oe), "value");
         check({dirReadback[7:6], outReadback[7:6], inReadback[7:6]} === eq.rb,
               "reads");
         check({dirReadback[5:0], outReadback[5:0], inReadback[5:0]} === eq.rbLo,
               "low reads");
         check({crystalPinMode7, crystalPinMode6} === eq.misc[4:3],
               "clock use");
         check(spi0SlaveActive === eq.misc[2], "slave active");
         check({usart0ClockIsOutput, usart1RxData} === eq.misc[1:0], "usart");
         check({spi0ClockIn, spi0MasterIn, spi0SlaveIn, usart0ClockIn} === eq.pin,
               "pad inputs");
         check(pinChangeSrc === eq.pc, "pin change");
      end
      eq <= calc();
      chkOn <= armed;
      cycles++;
      if (cycles > 2000) begin
         n_fail++;
         print_verdict();
      end
   end
   task automatic run(input int n, input logic [1:0] s, input logic [7:0] c);
      logic [7:0] k;
      repeat (n) begin
         @(posedge mclk);
         k = c[0] ? 8'($urandom) : c;
         {dirBits, outBits, extLevel, extDrive} <= $urandom;
         {globalPullupDisable, spi0ClockOut, spi0SlaveOut, spi0MasterOut, usart0ClockOut,
          usart1TxData, timer2CmpAEnable, timer2CmpA, timer1CmpBEnable, timer1CmpB,
          timer1CmpAEnable, timer1CmpA} <= 12'($urandom);
         {asyncTimer2Select, externalClockSelect} <= c[7:6];
         {spi0Enable, spi0Master, usart1RxEnable, usart1TxEnable, usart0SyncMode} <= k[5:1];
         chipClockSource <= pbm_clksrc_t'(s);
      end
   endtask
   logic [7:0] modes [9] = '{8'h00, 8'h20, 8'h30, 8'h10, 8'h08, 8'h04, 8'h24, 8'h38, 8'h02};
   initial begin
      {dirBits, outBits, extLevel, extDrive, globalPullupDisable, asyncTimer2Select} = '0;
      {externalClockSelect, spi0Enable, spi0Master, spi0ClockOut, spi0SlaveOut} = '0;
      {spi0MasterOut, usart0SyncMode, usart0ClockOut, usart1RxEnable, usart1TxEnable} = '0;
      {usart1TxData, timer2CmpAEnable, timer2CmpA, timer1CmpBEnable, timer1CmpB} = '0;
      {timer1CmpAEnable, timer1CmpA, rstn, armed, chkOn} = '0;
      chipClockSource = PBM_CLK_RC;
      void'($urandom(54113));
      repeat (6) @(posedge mclk);
      rstn <= 1'b1;
      repeat (4) @(posedge mclk);
      armed <= 1'b1;
      for (int s = 0; s < 3; s++)
         for (int a = 0; a < 4; a++)
            run(6, 2'(s), {2'(a), 6'h01});
      $display("test clock sources done");
      foreach (modes[m]) run(8, 2'h0, modes[m]);
      $display("test peripheral modes done");
      repeat (300) run(1, 2'($urandom % 3), {2'($urandom), 6'h01});
      $display("test random mix done");
      run(2, 2'h0, 8'h00);
      print_verdict();
   end
endmodule
